// [core/mcs_pkg.sv]
package mcs_pkg;
	// ============================================================
	// Register map (byte addresses on the APB bus)
	localparam logic [7:0] MCS_CTRL_OFS = 8'h00;
	localparam logic [7:0] MCS_STAT_OFS = 8'h04;
	localparam logic [7:0] MCS_IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] MCS_IRQ_EN_OFS = 8'h0c;
	localparam logic [7:0] MCS_IRQ_CLR_OFS = 8'h10;
	localparam logic [7:0] MCS_MGMT_OFS = 8'h14;

	// Control fields, used only while software control is selected.
	localparam int CTRL_W = 3;
	localparam int CTRL_FULL_BIT = 0;
	localparam int CTRL_REP_BIT = 1;
	localparam int CTRL_SPD_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;

	// Interrupt bits.
	localparam int IRQ_W = 4;
	localparam int IRQ_COL = 0;
	localparam int IRQ_CRS = 1;
	localparam int IRQ_SQE = 2;
	localparam int IRQ_MGMT = 3;
	localparam logic [3:0] IRQ_RST = 4'h0;

	// Signal quality error test timing.
	localparam int CLK_PERIOD_NS = 40;
	localparam int SQE_DELAY_NS = 1000;
	localparam int SQE_WIDTH_NS = 1000;
	localparam int SQE_DELAY_CYC = (SQE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SQE_WIDTH_CYC = (SQE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] SQE_DELAY_LD = 6'(SQE_DELAY_CYC - 1);
	localparam logic [5:0] SQE_WIDTH_LD = 6'(SQE_WIDTH_CYC - 1);
	localparam logic [5:0] SQE_CNT_ZERO = 6'h00;

	// Receive symbol width in 100 Mb/s mode.
	localparam int SYM_W = 10;

	// Management frame layout and the one local management register.
	localparam logic [4:0] MGMT_SQE_REG = 5'h12;
	localparam int MGMT_SQE_INH_BIT = 2;
	localparam logic [15:0] MGMT_REG_RST = 16'h0000;
	localparam logic [5:0] MGMT_PRE_MIN = 6'h20;
	localparam logic [4:0] MGMT_HDR_END = 5'h0c;
	localparam logic [4:0] MGMT_DATA0 = 5'h0e;
	localparam logic [4:0] MGMT_LAST = 5'h1d;
	localparam logic [1:0] MGMT_OP_WR = 2'h1;
	localparam logic [1:0] MGMT_OP_RD = 2'h2;

	// Synchroniser depth for pins from outside the clock domain.
	localparam int SYNC_STAGES = 3;

	// Effective operating mode.
	typedef struct packed {
		logic full;
		logic repeater;
		logic speed100;
	} mcs_mode_t;

	// Pins that cross into the pclk domain.
	typedef struct packed {
		logic hw_rst_n;
		logic sw_mode;
		logic repeater;
		logic duplex;
		logic speed100;
		logic tx_en;
		logic rx_line;
		logic rx_carrier;
		logic mdc;
		logic mdio;
		logic [4:0] phy;
	} mcs_pins_t;
endpackage

// [core/mcs_sync.sv]
`timescale 1ns/100ps
module mcs_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Asynchronous inputs and their filtered copies.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import mcs_pkg::*;

	logic [SYNC_STAGES-1:0][W-1:0] st_r;
	logic [SYNC_STAGES-1:0][W-1:0] st_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	// A bit changes only once the last two stages agree.
	always_comb begin
		st_nxt = {st_r[SYNC_STAGES-2:0], d};
		q_nxt = q_r;
		for (int i = 0; i < W; i++) begin
			if (st_r[SYNC_STAGES-1][i] == st_r[SYNC_STAGES-2][i]) begin
				q_nxt[i] = st_r[SYNC_STAGES-1][i];
			end
		end
	end

	// Stage registers.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
			q_r <= '0;
		end else begin
			st_r <= st_nxt;
			q_r <= q_nxt;
		end
	end

	assign q = q_r;
endmodule

// [core/mcs_mgmt.sv]
`timescale 1ns/100ps
module mcs_mgmt (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	// Synchronised management pins.
	input wire logic mdc_s,
	input wire logic mdio_s,
	input wire logic [4:0] phy_addr,
	// Data line drive.
	output logic mdio_drive,
	output logic mdio_drive_en,
	// Local register and write event.
	output logic [15:0] reg_q,
	output logic wr_done
);
	import mcs_pkg::*;

	typedef enum logic [1:0] {MG_IDLE, MG_START, MG_FRAME} mcs_mg_t;

	mcs_mg_t st_r, st_nxt;
	logic [5:0] pre_r, pre_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [11:0] hdr_r, hdr_nxt;
	logic [15:0] sh_r, sh_nxt;
	logic [15:0] reg_r, reg_nxt;
	logic o_r, o_nxt, oe_r, oe_nxt, mdc_d_r, wr_r, wr_nxt;
	logic rise, hit;

	// The station manager's clock is sampled; its rising edge times each bit.
	assign rise = mdc_s && !mdc_d_r;
	assign hit = (hdr_r[9:5] == phy_addr);

	// ============================================================
	// Frame decoder and responder
	always_comb begin
		st_nxt = st_r;
		pre_nxt = pre_r;
		cnt_nxt = cnt_r;
		hdr_nxt = hdr_r;
		sh_nxt = sh_r;
		reg_nxt = reg_r;
		o_nxt = o_r;
		oe_nxt = oe_r;
		wr_nxt = 1'b0;
		if (rise) begin
			case (st_r)
				MG_IDLE: begin
					if (mdio_s) begin
						pre_nxt = (pre_r == MGMT_PRE_MIN) ? pre_r : pre_r + 6'h01;
					end else begin
						if (pre_r == MGMT_PRE_MIN) st_nxt = MG_START;
						pre_nxt = 6'h00;
					end
				end
				MG_START: begin
					st_nxt = mdio_s ? MG_FRAME : MG_IDLE;
					cnt_nxt = 5'h00;
				end
				MG_FRAME: begin
					cnt_nxt = cnt_r + 5'h01;
					if (cnt_r < MGMT_HDR_END) hdr_nxt = {hdr_r[10:0], mdio_s};
					if (cnt_r == MGMT_HDR_END && hit && hdr_r[11:10] == MGMT_OP_RD) begin
						oe_nxt = 1'b1;
						o_nxt = 1'b0;
						sh_nxt = (hdr_r[4:0] == MGMT_SQE_REG) ? reg_r : 16'h0000;
					end else if (oe_r) begin
						o_nxt = sh_r[15];
						sh_nxt = {sh_r[14:0], 1'b0};
					end
					if (cnt_r >= MGMT_DATA0 && hdr_r[11:10] == MGMT_OP_WR) begin
						sh_nxt = {sh_r[14:0], mdio_s};
					end
					if (cnt_r == MGMT_LAST) begin
						oe_nxt = 1'b0;
						o_nxt = 1'b0;
						st_nxt = MG_IDLE;
						if (hit && hdr_r[11:10] == MGMT_OP_WR && hdr_r[4:0] == MGMT_SQE_REG) begin
							reg_nxt = {sh_r[14:0], mdio_s};
							wr_nxt = 1'b1;
						end
					end
				end
				default: st_nxt = MG_IDLE;
			endcase
		end
		if (!run) begin
			st_nxt = MG_IDLE;
			pre_nxt = 6'h00;
			cnt_nxt = 5'h00;
			reg_nxt = MGMT_REG_RST;
			o_nxt = 1'b0;
			oe_nxt = 1'b0;
		end
	end

	// Frame state registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= MG_IDLE;
			pre_r <= 6'h00;
			cnt_r <= 5'h00;
			hdr_r <= 12'h000;
			sh_r <= 16'h0000;
			reg_r <= MGMT_REG_RST;
			o_r <= 1'b0;
			oe_r <= 1'b0;
			mdc_d_r <= 1'b0;
			wr_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			pre_r <= pre_nxt;
			cnt_r <= cnt_nxt;
			hdr_r <= hdr_nxt;
			sh_r <= sh_nxt;
			reg_r <= reg_nxt;
			o_r <= o_nxt;
			oe_r <= oe_nxt;
			mdc_d_r <= mdc_s;
			wr_r <= wr_nxt;
		end
	end

	assign mdio_drive = o_r;
	assign mdio_drive_en = oe_r;
	assign reg_q = reg_r;
	assign wr_done = wr_r;

	// ============================================================
	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_mdio_read_only: assert property (oe_r |-> (hdr_r[11:10] == MGMT_OP_RD && hit))
		else $error("Data line driven outside an addressed read.");
	a_mdio_mdc_step: assert property ((run && $changed({o_r, oe_r})) |-> $past(rise))
		else $error("Data line changed without a management clock edge.");
endmodule

// [core/mcs_top.sv]
`timescale 1ns/100ps
module mcs_top (
	// APB slave.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Straps and configuration pins.
	input wire logic hardware_reset_low,
	input wire logic pin_or_register_control_select,
	input wire logic node_repeater_select,
	input wire logic speed_100_select,
	input wire logic [4:0] phy_address,
	input wire logic duplex_select_pin,
	output logic duplex_select_drive,
	output logic duplex_select_drive_en,
	// MII status.
	input wire logic tx_en,
	input wire logic rx_line_active,
	input wire logic rx_carrier,
	input wire logic [mcs_pkg::SYM_W-1:0] rx_symbol,
	input wire logic rx_symbol_valid,
	output logic col,
	output logic crs,
	// Serial management.
	input wire logic mdc,
	input wire logic mdio_sample,
	output logic mdio_drive,
	output logic mdio_drive_en,
	// Interrupt.
	output logic irq
);
	import mcs_pkg::*;

	// ============================================================
	// Pin synchronisers and hardware reset
	mcs_pins_t pins_raw;
	mcs_pins_t pins_s;
	logic run;
	// All asynchronous pins are filtered into the pclk domain.
	assign pins_raw = {hardware_reset_low, pin_or_register_control_select,
		node_repeater_select, duplex_select_pin, speed_100_select, tx_en,
		rx_line_active, rx_carrier, mdc, mdio_sample, phy_address};
	mcs_sync #(.W($bits(mcs_pins_t))) u_sync (.clk(pclk), .rst_n(presetn),
		.d(pins_raw), .q(pins_s));
	// All but the bus, the control and interrupt enable registers and the duplex drive register run only while the hardware reset pin is high.
	assign run = pins_s.hw_rst_n;

	// ============================================================
	// Management responder
	logic [15:0] mgmt_reg;
	logic mgmt_wr;
	logic sqe_inh;

	mcs_mgmt u_mgmt (
		.pclk(pclk),
		.presetn(presetn),
		.run(run),
		.mdc_s(pins_s.mdc),
		.mdio_s(pins_s.mdio),
		.phy_addr(pins_s.phy),
		.mdio_drive(mdio_drive),
		.mdio_drive_en(mdio_drive_en),
		.reg_q(mgmt_reg),
		.wr_done(mgmt_wr)
	);
	assign sqe_inh = mgmt_reg[MGMT_SQE_INH_BIT];

	// ============================================================
	// Mode selection
	logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
	mcs_mode_t mode;

	// Pins decide in pin control; the control register decides otherwise.
	assign mode.full = pins_s.sw_mode ? ctrl_r[CTRL_FULL_BIT] : pins_s.duplex;
	assign mode.repeater = pins_s.sw_mode ? ctrl_r[CTRL_REP_BIT] : pins_s.repeater;
	assign mode.speed100 = pins_s.sw_mode ? ctrl_r[CTRL_SPD_BIT] : pins_s.speed100;

	// ============================================================
	// Receive activity
	function automatic logic two_gap(input logic [SYM_W-1:0] s);
		logic g;
		g = 1'b0;
		for (int i = 0; i < SYM_W - 2; i++) begin
			for (int j = i + 2; j < SYM_W; j++) begin
				g = g | (!s[i] && !s[j]);
			end
		end
		return g;
	endfunction

	logic act100_r, act100_nxt;
	logic rx_act, rx_crs;

	// Each symbol decides whether the 100 Mb/s line is active.
	always_comb begin
		act100_nxt = act100_r;
		if (!run || !mode.speed100) begin
			act100_nxt = 1'b0;
		end else if (rx_symbol_valid) begin
			act100_nxt = two_gap(rx_symbol);
		end
	end

	// Activity register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act100_r <= 1'b0;
		end else begin
			act100_r <= act100_nxt;
		end
	end

	// At 10 Mb/s collision watches the unsquelched line, carrier the squelched one; at 100 Mb/s both watch symbol activity.
	assign rx_act = mode.speed100 ? act100_r : pins_s.rx_line;
	assign rx_crs = mode.speed100 ? act100_r : pins_s.rx_carrier;

	// ============================================================
	// SQE test sequencer
	typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_PULSE} mcs_sqe_t;
	mcs_sqe_t sq_r, sq_nxt;
	logic [5:0] sq_cnt_r, sq_cnt_nxt;
	logic tx_d_r;
	logic sqe_ok, sqe_on, sqe_done;
	// The test runs only in 10 Mb/s half-duplex node mode when not inhibited.
	assign sqe_ok = run && !mode.full && !mode.repeater && !mode.speed100 && !sqe_inh;
	assign sqe_on = (sq_r == SQ_PULSE);
	assign sqe_done = sqe_on && (sq_cnt_r == SQE_CNT_ZERO);
	// Wait after transmit ends, then pulse for a fixed width.
	always_comb begin
		sq_nxt = sq_r;
		sq_cnt_nxt = sq_cnt_r;
		case (sq_r)
			SQ_IDLE: begin
				if (tx_d_r && !pins_s.tx_en) begin
					sq_nxt = SQ_WAIT;
					sq_cnt_nxt = SQE_DELAY_LD;
				end
			end
			SQ_WAIT: begin
				if (sq_cnt_r == SQE_CNT_ZERO) begin
					sq_nxt = SQ_PULSE;
					sq_cnt_nxt = SQE_WIDTH_LD;
				end else begin
					sq_cnt_nxt = sq_cnt_r - 6'h01;
				end
			end
			SQ_PULSE: begin
				if (sq_cnt_r == SQE_CNT_ZERO) begin
					sq_nxt = SQ_IDLE;
				end else begin
					sq_cnt_nxt = sq_cnt_r - 6'h01;
				end
			end
			default: sq_nxt = SQ_IDLE;
		endcase
		if (!sqe_ok || pins_s.tx_en) begin
			sq_nxt = SQ_IDLE;
			sq_cnt_nxt = SQE_CNT_ZERO;
		end
	end

	// Sequencer registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sq_r <= SQ_IDLE;
			sq_cnt_r <= SQE_CNT_ZERO;
			tx_d_r <= 1'b0;
		end else begin
			sq_r <= sq_nxt;
			sq_cnt_r <= sq_cnt_nxt;
			tx_d_r <= pins_s.tx_en;
		end
	end

	// ============================================================
	// Collision and carrier outputs
	logic col_r, col_nxt, crs_r, crs_nxt, dpx_r, dpx_nxt;
	// Both outputs follow their causes and fall as soon as those end.
	always_comb begin
		col_nxt = run && !mode.full && ((pins_s.tx_en && rx_act) || sqe_on);
		crs_nxt = run && (rx_crs || (pins_s.tx_en && !mode.full && !mode.repeater));
		dpx_nxt = mode.full;
	end
	// Output registers; they change on pclk, not on any data clock.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			col_r <= 1'b0;
			crs_r <= 1'b0;
			dpx_r <= 1'b0;
		end else begin
			col_r <= col_nxt;
			crs_r <= crs_nxt;
			dpx_r <= dpx_nxt;
		end
	end

	assign col = col_r;
	assign crs = crs_r;
	assign duplex_select_drive = dpx_r;
	assign duplex_select_drive_en = pins_s.sw_mode;

	// ============================================================
	// Register file and interrupts
	logic [IRQ_W-1:0] ev, irq_st_r, irq_st_nxt, irq_en_r, irq_en_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic setup, wr_acc, mapped;
	// Setup phase and write access phase of the bus.
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	// Rising edges of collision and carrier, SQE end and management writes.
	always_comb begin
		ev = '0;
		ev[IRQ_COL] = col_nxt && !col_r;
		ev[IRQ_CRS] = crs_nxt && !crs_r;
		ev[IRQ_SQE] = sqe_done;
		ev[IRQ_MGMT] = mgmt_wr;
	end
	// Address decode for the error answer.
	always_comb begin
		case (paddr)
			MCS_CTRL_OFS, MCS_STAT_OFS, MCS_IRQ_STAT_OFS,
			MCS_IRQ_EN_OFS, MCS_IRQ_CLR_OFS, MCS_MGMT_OFS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end
	// Writes in the access phase; read data is fetched in the setup phase.
	always_comb begin
		ctrl_nxt = ctrl_r;
		irq_en_nxt = irq_en_r;
		irq_st_nxt = irq_st_r;
		rdata_nxt = rdata_r;
		if (wr_acc) begin
			case (paddr)
				MCS_CTRL_OFS: ctrl_nxt = pwdata[CTRL_W-1:0];
				MCS_IRQ_EN_OFS: irq_en_nxt = pwdata[IRQ_W-1:0];
				MCS_IRQ_CLR_OFS: irq_st_nxt = irq_st_r & ~pwdata[IRQ_W-1:0];
				default: ;
			endcase
		end
		irq_st_nxt = run ? (irq_st_nxt | ev) : IRQ_RST;
		if (setup && !pwrite) begin
			case (paddr)
				MCS_CTRL_OFS: rdata_nxt = {29'h0, ctrl_r};
				MCS_STAT_OFS: rdata_nxt = {24'h0, !run, sqe_inh, pins_s.sw_mode, mode, crs_r, col_r};
				MCS_IRQ_STAT_OFS: rdata_nxt = {28'h0, irq_st_r};
				MCS_IRQ_EN_OFS: rdata_nxt = {28'h0, irq_en_r};
				MCS_MGMT_OFS: rdata_nxt = {16'h0, mgmt_reg};
				default: rdata_nxt = 32'h0;
			endcase
		end
	end
	// Register file flip-flops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= CTRL_RST;
			irq_en_r <= IRQ_RST;
			irq_st_r <= IRQ_RST;
			rdata_r <= 32'h0;
		end else begin
			ctrl_r <= ctrl_nxt;
			irq_en_r <= irq_en_nxt;
			irq_st_r <= irq_st_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign prdata = rdata_r;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign irq = |(irq_st_r & irq_en_r);

	// ============================================================
	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_overlap;
		run && !mode.full && pins_s.tx_en && rx_act;
	endsequence
	sequence s_hw_reset;
		!run [*2];
	endsequence
	sequence s_node_tx;
		run && !mode.full && !mode.repeater && pins_s.tx_en;
	endsequence

	a_col_on_overlap: assert property (s_overlap |=> col)
		else $error("Collision missing during transmit and receive overlap.");
	a_col_tenm_line: assert property ((run && !mode.full && !mode.speed100 && pins_s.tx_en
		&& pins_s.rx_line) |=> col)
		else $error("Collision missing for 10 Mb/s line activity.");
	a_sym_activity: assert property ((run && mode.speed100 && rx_symbol_valid
		&& two_gap(rx_symbol)) |=> act100_r)
		else $error("Qualifying symbol did not mark activity.");
	a_col_full_low: assert property (mode.full |=> !col)
		else $error("Collision raised in full duplex.");
	a_sqe_inhibited: assert property (sqe_inh |=> !sqe_on)
		else $error("SQE pulse while inhibited.");
	a_crs_node_tx: assert property (s_node_tx |=> crs)
		else $error("Carrier missing for own transmission.");
	a_crs_rx_only: assert property (((mode.full || mode.repeater) && !rx_crs) |=> !crs)
		else $error("Carrier raised without receive activity.");
	a_col_release: assert property ((!pins_s.tx_en && !sqe_on) |=> !col)
		else $error("Collision held after activity ended.");
	a_reset_quiet: assert property (s_hw_reset |-> (!col && !crs && !mdio_drive_en))
		else $error("Outputs active during hardware reset.");
	a_duplex_pin: assert property ((!pins_s.sw_mode && pins_s.duplex) |=> !col)
		else $error("Duplex pin high did not block collision.");
	a_repeater_pin: assert property ((!pins_s.sw_mode && pins_s.repeater && !rx_crs)
		|=> !crs)
		else $error("Repeater select did not drop transmit carrier.");
endmodule

// [dv/mcs_sta_model.sv]
`timescale 1ns/100ps
// ============================================================
// Station manager model that makes the management clock and runs frames.
module mcs_sta_model (
	// Management clock and data line.
	output logic mdc,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic mdio_line
);
	import mcs_pkg::*;
	// The clock stands low and the line is released between frames.
	initial begin
		mdc = 1'h0;
		mdio_out = 1'h1;
		mdio_oe = 1'h0;
	end
	// One frame of 64 bits, MSB first; a read releases turnaround and data.
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] bits;
		bits = {32'hffffffff, 2'h1, op, phy, ra, 2'h2, wd};
		rd = 16'h0000;
		#7;
		for (int i = 63; i >= 0; i--) begin
			mdio_oe = !(op == MGMT_OP_RD && i < 18);
			mdio_out = mdio_oe ? bits[i] : !mdio_out;
			#160 mdc = 1'h1;
			if (i < 16) begin
				rd[i] = mdio_line;
			end
			#160 mdc = 1'h0;
		end
		mdio_oe = 1'h0;
	endtask
endmodule

// [dv/mcs_top_bench.sv]
`timescale 1ns/100ps
// ============================================================
// Bench for collision, carrier sense and the management line.
module mcs_top_bench;
	import mcs_pkg::*;
	localparam logic [4:0] PHY = 5'h05;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic hardware_reset_low, pin_or_register_control_select, node_repeater_select;
	logic speed_100_select, dpx_b, duplex_select_drive, duplex_select_drive_en;
	logic tx_en, rx_line_active, rx_carrier, rx_symbol_valid, col, crs;
	logic [SYM_W-1:0] rx_symbol;
	logic mdc, mdio_out, mdio_oe, mdio_drive, mdio_drive_en, irq;
	logic [15:0] md;
	int fails, tests_run;
	int cycles = 0;
	// The data line has a pull-up; the duplex pin is two-way.
	wire mdio_line = mdio_drive_en ? mdio_drive : (mdio_oe ? mdio_out : 1'h1);
	wire dpx_line = duplex_select_drive_en ? duplex_select_drive : dpx_b;

	mcs_top u_mcs_top (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .hardware_reset_low, .pin_or_register_control_select,
		.node_repeater_select, .speed_100_select, .phy_address(PHY),
		.duplex_select_pin(dpx_line), .duplex_select_drive, .duplex_select_drive_en,
		.tx_en, .rx_line_active, .rx_carrier, .rx_symbol, .rx_symbol_valid, .col, .crs,
		.mdc, .mdio_sample(mdio_line), .mdio_drive, .mdio_drive_en, .irq
	);
	mcs_sta_model u_mcs_sta_model (.mdc, .mdio_out, .mdio_oe, .mdio_line);

	// Clock of 40 ns.
	initial pclk = 1'h0;
	always #20 pclk = ~pclk;
	// A hang is cut short after a fixed number of cycles.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			results();
		end
	end

	// ============================================================
	// Shared tasks.
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic cb(input string n, input logic e, input logic g);
		chk(n, {31'h0, e}, {31'h0, g});
	endtask
	// One transfer; held until pready is seen high at a rising edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1) @(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic sym(input logic [SYM_W-1:0] v);
		rx_symbol <= v;
		rx_symbol_valid <= 1'h1;
		wt(1);
		rx_symbol_valid <= 1'h0;
	endtask
	task automatic results;
		$display("Checks run %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ============================================================
	// Scenarios.
	task automatic t_regs;
		apb(1'h0, MCS_CTRL_OFS, 32'h0);
		chk("ctrl reset", {29'h0, CTRL_RST}, rdat);
		cb("mapped no error", 1'h0, rerr);
		apb(1'h0, MCS_IRQ_EN_OFS, 32'h0);
		chk("irq_en reset", {28'h0, IRQ_RST}, rdat);
		apb(1'h0, 8'h18, 32'h0);
		cb("unmapped error", 1'h1, rerr);
		chk("unmapped data", 32'h0, rdat);
		apb(1'h1, MCS_CTRL_OFS, 32'h7);
		apb(1'h0, MCS_CTRL_OFS, 32'h0);
		chk("ctrl readback", 32'h7, rdat);
		pin_or_register_control_select <= 1'h1;
		wt(8);
		cb("duplex drive", 1'h1, duplex_select_drive & duplex_select_drive_en);
		apb(1'h0, MCS_STAT_OFS, 32'h0);
		chk("stat mode", 32'h3c, rdat & 32'h3c);
		pin_or_register_control_select <= 1'h0;
		apb(1'h1, MCS_CTRL_OFS, 32'h0);
	endtask
	task automatic t_col;
		apb(1'h1, MCS_IRQ_EN_OFS, 32'h1);
		tx_en <= 1'h1;
		rx_line_active <= 1'h1;
		wt(8);
		cb("col on rx during tx", 1'h1, col);
		cb("crs on tx", 1'h1, crs);
		cb("irq raised", 1'h1, irq);
		apb(1'h0, MCS_STAT_OFS, 32'h0);
		chk("stat col crs", 32'h3, rdat & 32'h3);
		apb(1'h1, MCS_IRQ_EN_OFS, 32'h0);
		wt(2);
		cb("irq masked", 1'h0, irq);
		rx_line_active <= 1'h0;
		wt(8);
		cb("col drops", 1'h0, col);
		cb("crs on tx alone", 1'h1, crs);
		tx_en <= 1'h0;
		wt(42);
		cb("sqe pulse", 1'h1, col);
		cb("crs drops", 1'h0, crs);
		wt(20);
		cb("sqe ends", 1'h0, col);
		apb(1'h0, MCS_IRQ_STAT_OFS, 32'h0);
		chk("irq status", 32'h7, rdat);
		apb(1'h1, MCS_IRQ_CLR_OFS, 32'hf);
		apb(1'h0, MCS_IRQ_STAT_OFS, 32'h0);
		chk("irq cleared", 32'h0, rdat);
	endtask
	task automatic t_mgmt;
		u_mcs_sta_model.frame(MGMT_OP_WR, PHY, MGMT_SQE_REG, 16'h0004, md);
		u_mcs_sta_model.frame(MGMT_OP_RD, PHY, MGMT_SQE_REG, 16'h0000, md);
		chk("mgmt read", 32'h4, {16'h0, md});
		u_mcs_sta_model.frame(MGMT_OP_RD, PHY ^ 5'h01, MGMT_SQE_REG, 16'h0000, md);
		chk("other phy idle", 32'hffff, {16'h0, md});
		apb(1'h0, MCS_MGMT_OFS, 32'h0);
		chk("mgmt via apb", 32'h4, rdat);
		apb(1'h0, MCS_IRQ_STAT_OFS, 32'h0);
		chk("irq mgmt write", 32'h8, rdat);
		apb(1'h0, MCS_STAT_OFS, 32'h0);
		chk("stat inhibit", 32'h40, rdat & 32'h40);
		tx_en <= 1'h1;
		wt(8);
		tx_en <= 1'h0;
		wt(45);
		cb("sqe inhibited", 1'h0, col);
	endtask
	task automatic t_full;
		dpx_b <= 1'h1;
		wt(8);
		tx_en <= 1'h1;
		rx_line_active <= 1'h1;
		rx_carrier <= 1'h1;
		wt(8);
		cb("col in full duplex", 1'h0, col);
		cb("crs on rx", 1'h1, crs);
		rx_line_active <= 1'h0;
		rx_carrier <= 1'h0;
		wt(8);
		cb("crs not on tx", 1'h0, crs);
		tx_en <= 1'h0;
		dpx_b <= 1'h0;
	endtask
	task automatic t_rep;
		node_repeater_select <= 1'h1;
		wt(8);
		tx_en <= 1'h1;
		wt(8);
		cb("repeater crs on tx", 1'h0, crs);
		rx_carrier <= 1'h1;
		wt(8);
		cb("repeater crs on rx", 1'h1, crs);
		tx_en <= 1'h0;
		rx_carrier <= 1'h0;
		node_repeater_select <= 1'h0;
	endtask
	task automatic t_100;
		speed_100_select <= 1'h1;
		tx_en <= 1'h1;
		wt(8);
		sym(10'h3ed);
		wt(3);
		cb("col on split zeros", 1'h1, col);
		cb("crs on symbol", 1'h1, crs);
		sym(10'h3f9);
		wt(3);
		cb("no col on adjacent zeros", 1'h0, col);
		tx_en <= 1'h0;
		wt(8);
		cb("crs drops with activity", 1'h0, crs);
		speed_100_select <= 1'h0;
	endtask
	task automatic t_hwrst;
		wt(8);
		tx_en <= 1'h1;
		rx_line_active <= 1'h1;
		wt(8);
		cb("col before reset", 1'h1, col);
		hardware_reset_low <= 1'h0;
		wt(8);
		cb("col in reset", 1'h0, col);
		cb("crs in reset", 1'h0, crs);
		apb(1'h0, MCS_STAT_OFS, 32'h0);
		chk("stat in reset", 32'h80, rdat & 32'h80);
		apb(1'h0, MCS_MGMT_OFS, 32'h0);
		chk("mgmt cleared", 32'h0, rdat);
		hardware_reset_low <= 1'h1;
		wt(8);
		cb("col after reset", 1'h1, col);
	endtask

	// Main sequence.
	initial begin
		fails = 0;
		tests_run = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{pin_or_register_control_select, node_repeater_select, speed_100_select} = 3'h0;
		{dpx_b, tx_en, rx_line_active, rx_carrier, rx_symbol_valid} = 5'h0;
		rx_symbol = '1;
		hardware_reset_low = 1'h1;
		presetn = 1'h0;
		wt(4);
		presetn <= 1'h1;
		wt(10);
		t_regs();
		t_col();
		t_mgmt();
		t_full();
		t_rep();
		t_100();
		t_hwrst();
		results();
	end
endmodule
